/* logic/user_otp_status_registers.v */
// User OTP configuration bytes, status flags and Avalon-MM slave of the sensor
//
// Contract
// - With extension bit clear, init phase 2 fields D27 to D32 send zeros.
// - With extension bit set, D27 to D32 carry their extended content in 10-bit mode only.
// - Direction field maps to D8 nibble as value shifted left by two.
// - Four-bit product revision is stored and reported in 10-bit init phase 2.
// - Stored year means 2009 plus value; Julian year code is value plus nine.
// - Month and day fields pass unchanged as Julian month and day.
// - Julian date codes go to the ECU in init phase 2 with 10-bit data.
// - Manufacturing bytes never touch sensing; forwarded only in 10-bit mode.
// - The three spare user bits are stored and affect nothing.
// - Asynchronous bit together with time slot selects asynchronous answering.
// - Zero slot gives default or async by the bit; nonzero slot ignores it.
// - Status byte is read-only; bits 7 and 0 read zero, bit 5 reserved.
// - Test flag reads zero while test mode is active, one otherwise.
// - User data flag clears on user array mismatch and stays until reset.
// - Factory data flag clears on factory CRC fault and stays until reset.
// - Offset cancel flag is zero in initialization, one after both intervals.
// - Offset flag clears while the signal reaches the offset limit.
// - Eight-bit maker code is stored and sent in 10-bit init phase 2.
`timescale 1ns/1ps
`include "user_otp_regs.vh"
module user_otp_status_registers
(
	input wire clk,
	input wire resetn,
	input wire [7:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	input wire [3:0] byteenable,
	output reg [31:0] readdata,
	output reg waitrequest,
	output reg irq_q,
	input wire ten_bit_mode,
	input wire [9:0] timeslot_sel,
	input wire [23:0] ext_content,
	input wire test_mode_active,
	input wire user_mismatch,
	input wire factory_crc_fault,
	input wire oc_intervals_expired,
	input wire filter_normal_mode,
	input wire offset_limit_hit,
	output reg [1:0] slot_mode_q,
	output reg [9:0] slot_half_us_q,
	output wire [3:0] d8_direction_q,
	output wire [3:0] revision_q,
	output wire [6:0] julian_year_q,
	output wire [3:0] julian_month_q,
	output wire [4:0] julian_day_q,
	output wire [7:0] maker_code_q,
	output wire [23:0] ext_fields_q
);

	localparam ST_IDLE = 1'b0;
	localparam ST_ANSWER = 1'b1;

	reg state_q;
	reg [7:0] init_direction_revision_q;
	reg [7:0] production_year_month_q;
	reg [7:0] production_day_spare_q;
	reg [7:0] maker_reg_q;
	reg test_active_low_q;
	reg user_data_ok_q;
	reg factory_data_ok_q;
	reg offset_cancel_done_q;
	reg offset_ok_q;
	reg [4:0] irq_status_q;
	reg [4:0] irq_mask_q;
	reg [4:0] irq_status_d;
	reg [4:0] events;
	reg [7:0] read_mux;
	wire [5:0] reg_index;
	wire aligned;
	wire request;
	wire commit_write;
	wire lane0;
	wire [7:0] wbyte;
	wire [7:0] device_status_flags;
	wire phase2_extension_enable;
	wire async_enable;
	wire [1:0] direction;
	wire [3:0] revision;
	wire [3:0] year;
	wire [3:0] month;
	wire [4:0] day;
	wire [2:0] spare_user_bits;

	assign reg_index = address[7:2];
	assign aligned = (address[1:0] == 2'h0);
	assign request = read | write;
	assign commit_write = write & (state_q == ST_ANSWER);
	assign lane0 = byteenable[0];
	assign wbyte = writedata[7:0];

	assign phase2_extension_enable = init_direction_revision_q[`POS_EXT_EN];
	assign async_enable = init_direction_revision_q[`POS_ASYNC];
	assign direction = init_direction_revision_q[`POS_DIR_HI:`POS_DIR_LO];
	assign revision = init_direction_revision_q[`POS_REV_HI:`POS_REV_LO];
	assign year = production_year_month_q[`POS_YEAR_HI:`POS_YEAR_LO];
	assign month = production_year_month_q[`POS_MONTH_HI:`POS_MONTH_LO];
	assign day = production_day_spare_q[`POS_DAY_HI:`POS_DAY_LO];
	assign spare_user_bits = production_day_spare_q[`POS_SPARE_HI:`POS_SPARE_LO];

	// Status byte assembled with fixed zero bits
	assign device_status_flags = {
		1'b0,
		test_active_low_q,
		1'b0,
		user_data_ok_q,
		offset_cancel_done_q,
		factory_data_ok_q,
		offset_ok_q,
		1'b0
	};

	// Bus handshake: request taken, answered one edge later
	always @(posedge clk)
	begin
		if (!resetn)
		begin
			state_q <= ST_IDLE;
			waitrequest <= 1'b1;
		end
		else
		begin
			case (state_q)
				ST_IDLE:
				begin
					if (request)
					begin
						state_q <= ST_ANSWER;
						waitrequest <= 1'b0;
					end
					else
					begin
						waitrequest <= 1'b1;
					end
				end
				ST_ANSWER:
				begin
					state_q <= ST_IDLE;
					waitrequest <= 1'b1;
				end
				default:
				begin
					state_q <= ST_IDLE;
					waitrequest <= 1'b1;
				end
			endcase
		end
	end

	// Read multiplexer
	always @*
	begin
		read_mux = 8'h00;
		if (aligned)
		begin
			case (reg_index)
				`IDX_INIT_DIR_REV: read_mux = init_direction_revision_q;
				`IDX_YEAR_MONTH: read_mux = production_year_month_q;
				`IDX_DAY_SPARE: read_mux = {spare_user_bits, day};
				`IDX_STATUS_FLAGS: read_mux = device_status_flags;
				`IDX_MAKER_CODE: read_mux = maker_reg_q;
				`IDX_IRQ_STATUS: read_mux = {3'h0, irq_status_q};
				`IDX_IRQ_MASK: read_mux = {3'h0, irq_mask_q};
				`IDX_SLOT_STATE: read_mux = {6'h00, slot_mode_q};
				default: read_mux = 8'h00;
			endcase
		end
	end

	always @(posedge clk)
	begin
		if (!resetn)
			readdata <= 32'h00000000;
		else if (read && state_q == ST_IDLE)
			readdata <= {24'h000000, read_mux};
	end

	// Configuration bytes, written only through lane 0
	always @(posedge clk)
	begin
		if (!resetn)
		begin
			init_direction_revision_q <= `RST_CFG;
			production_year_month_q <= `RST_CFG;
			production_day_spare_q <= `RST_CFG;
			maker_reg_q <= `RST_MAKER;
		end
		else if (commit_write && aligned && lane0)
		begin
			case (reg_index)
				`IDX_INIT_DIR_REV: init_direction_revision_q <= wbyte;
				`IDX_YEAR_MONTH: production_year_month_q <= wbyte;
				`IDX_DAY_SPARE: production_day_spare_q <= wbyte;
				`IDX_MAKER_CODE: maker_reg_q <= wbyte;
				default: maker_reg_q <= maker_reg_q;
			endcase
		end
	end

	// Test flag follows the mode, active low
	always @(posedge clk)
	begin
		if (!resetn)
			test_active_low_q <= 1'b1;
		else
			test_active_low_q <= ~test_mode_active;
	end

	// Latched integrity flags, only reset restores them
	always @(posedge clk)
	begin
		if (!resetn)
		begin
			user_data_ok_q <= 1'b1;
			factory_data_ok_q <= 1'b1;
		end
		else
		begin
			if (user_mismatch)
				user_data_ok_q <= 1'b0;
			if (factory_crc_fault)
				factory_data_ok_q <= 1'b0;
		end
	end

	// Offset cancellation completion, sticky once reached
	always @(posedge clk)
	begin
		if (!resetn)
			offset_cancel_done_q <= 1'b0;
		else if (oc_intervals_expired && filter_normal_mode)
			offset_cancel_done_q <= 1'b1;
	end

	// Offset flag tracks the limit detector
	always @(posedge clk)
	begin
		if (!resetn)
			offset_ok_q <= 1'b1;
		else
			offset_ok_q <= ~offset_limit_hit;
	end

	// Time slot selection
	always @(posedge clk)
	begin
		if (!resetn)
		begin
			slot_mode_q <= `SLOT_DEFAULT;
			slot_half_us_q <= `SLOT_ZERO;
		end
		else if (timeslot_sel != `SLOT_ZERO)
		begin
			slot_mode_q <= `SLOT_PROGRAMMED;
			slot_half_us_q <= timeslot_sel;
		end
		else if (async_enable)
		begin
			slot_mode_q <= `SLOT_ASYNC;
			slot_half_us_q <= `SLOT_ZERO;
		end
		else
		begin
			slot_mode_q <= `SLOT_DEFAULT;
			slot_half_us_q <= `SLOT_ZERO;
		end
	end

	// Interrupt events, taken from flag transitions
	always @*
	begin
		events = 5'h00;
		events[`EV_USER_ERR] = user_mismatch & user_data_ok_q;
		events[`EV_FACT_ERR] = factory_crc_fault & factory_data_ok_q;
		events[`EV_OFFSET_ERR] = offset_limit_hit & offset_ok_q;
		events[`EV_OC_DONE] = oc_intervals_expired & filter_normal_mode
			& ~offset_cancel_done_q;
		events[`EV_TEST_ENTRY] = test_mode_active & test_active_low_q;
	end

	// Write one to clear, new event wins over the clear
	always @*
	begin
		irq_status_d = irq_status_q;
		if (commit_write && aligned && lane0 && reg_index == `IDX_IRQ_STATUS)
			irq_status_d = irq_status_q & ~wbyte[4:0];
		irq_status_d = irq_status_d | events;
	end

	always @(posedge clk)
	begin
		if (!resetn)
		begin
			irq_status_q <= 5'h00;
			irq_mask_q <= `RST_IRQ_MASK;
			irq_q <= 1'b0;
		end
		else
		begin
			irq_status_q <= irq_status_d;
			if (commit_write && aligned && lane0 && reg_index == `IDX_IRQ_MASK)
				irq_mask_q <= wbyte[4:0];
			irq_q <= |(irq_status_d & irq_mask_q);
		end
	end

	// Init phase 2 field encoder
	init2_field_encoder u_encoder
	(
		.clk(clk),
		.resetn(resetn),
		.ten_bit_mode(ten_bit_mode),
		.phase2_extension_enable(phase2_extension_enable),
		.direction(direction),
		.revision(revision),
		.year(year),
		.month(month),
		.day(day),
		.maker_code(maker_reg_q),
		.ext_content(ext_content),
		.d8_direction_q(d8_direction_q),
		.revision_q(revision_q),
		.julian_year_q(julian_year_q),
		.julian_month_q(julian_month_q),
		.julian_day_q(julian_day_q),
		.maker_code_q(maker_code_q),
		.ext_fields_q(ext_fields_q)
	);

endmodule

/* logic/user_otp_regs.vh */
// Register indices, field positions, reset values and codes of the user OTP bank
`ifndef USER_OTP_REGS_VH
`define USER_OTP_REGS_VH

`define IDX_INIT_DIR_REV 6'h09
`define IDX_YEAR_MONTH 6'h0A
`define IDX_DAY_SPARE 6'h0B
`define IDX_STATUS_FLAGS 6'h0C
`define IDX_MAKER_CODE 6'h0D
`define IDX_IRQ_STATUS 6'h10
`define IDX_IRQ_MASK 6'h11
`define IDX_SLOT_STATE 6'h12

`define RST_CFG 8'h00
`define RST_MAKER 8'h00
`define RST_IRQ_MASK 5'h00

`define POS_EXT_EN 7
`define POS_ASYNC 6
`define POS_DIR_HI 5
`define POS_DIR_LO 4
`define POS_REV_HI 3
`define POS_REV_LO 0
`define POS_MONTH_HI 7
`define POS_MONTH_LO 4
`define POS_YEAR_HI 3
`define POS_YEAR_LO 0
`define POS_SPARE_HI 7
`define POS_SPARE_LO 5
`define POS_DAY_HI 4
`define POS_DAY_LO 0

`define POS_ST_TEST 6
`define POS_ST_USER_OK 4
`define POS_ST_OC_DONE 3
`define POS_ST_FACT_OK 2
`define POS_ST_OFFSET_OK 1

`define EV_USER_ERR 0
`define EV_FACT_ERR 1
`define EV_OFFSET_ERR 2
`define EV_OC_DONE 3
`define EV_TEST_ENTRY 4
`define EV_COUNT 5

`define JULIAN_YEAR_BASE 7'h09
`define SLOT_DEFAULT 2'h0
`define SLOT_ASYNC 2'h1
`define SLOT_PROGRAMMED 2'h2
`define SLOT_ZERO 10'h000

`endif

/* logic/init2_field_encoder.v */
// Builds the registered init phase 2 data fields from the user configuration bytes
`timescale 1ns/1ps
module init2_field_encoder
(
	input wire clk,
	input wire resetn,
	input wire ten_bit_mode,
	input wire phase2_extension_enable,
	input wire [1:0] direction,
	input wire [3:0] revision,
	input wire [3:0] year,
	input wire [3:0] month,
	input wire [4:0] day,
	input wire [7:0] maker_code,
	input wire [23:0] ext_content,
	output reg [3:0] d8_direction_q,
	output reg [3:0] revision_q,
	output reg [6:0] julian_year_q,
	output reg [3:0] julian_month_q,
	output reg [4:0] julian_day_q,
	output reg [7:0] maker_code_q,
	output reg [23:0] ext_fields_q
);

	wire [6:0] julian_year_d;

	assign julian_year_d = {3'h0, year} + `JULIAN_YEAR_BASE;

	always @(posedge clk)
	begin
		if (!resetn)
		begin
			d8_direction_q <= 4'h0;
			revision_q <= 4'h0;
			julian_year_q <= 7'h00;
			julian_month_q <= 4'h0;
			julian_day_q <= 5'h00;
			maker_code_q <= 8'h00;
			ext_fields_q <= 24'h000000;
		end
		else if (ten_bit_mode)
		begin
			d8_direction_q <= {direction, 2'h0};
			revision_q <= revision;
			julian_year_q <= julian_year_d;
			julian_month_q <= month;
			julian_day_q <= day;
			maker_code_q <= maker_code;
			if (phase2_extension_enable)
				ext_fields_q <= ext_content;
			else
				ext_fields_q <= 24'h000000;
		end
		else
		begin
			d8_direction_q <= 4'h0;
			revision_q <= 4'h0;
			julian_year_q <= 7'h00;
			julian_month_q <= 4'h0;
			julian_day_q <= 5'h00;
			maker_code_q <= 8'h00;
			ext_fields_q <= 24'h000000;
		end
	end

endmodule

/* dv/otp_regs_sva.sv */
// Assertions on the ports of the user OTP register bank
`timescale 1ns/1ps
module otp_regs_sva
(
	input logic clk,
	input logic resetn,
	input logic [7:0] address,
	input logic read,
	input logic write,
	input logic [31:0] writedata,
	input logic [3:0] byteenable,
	input logic [31:0] readdata,
	input logic waitrequest,
	input logic ten_bit_mode,
	input logic [9:0] timeslot_sel,
	input logic test_mode_active,
	input logic user_mismatch,
	input logic factory_crc_fault,
	input logic oc_intervals_expired,
	input logic filter_normal_mode,
	input logic offset_limit_hit,
	input logic [1:0] slot_mode_q,
	input logic [9:0] slot_half_us_q,
	input logic [3:0] d8_direction_q,
	input logic [6:0] julian_year_q,
	input logic [23:0] ext_fields_q
);
	logic user_seen_q;
	logic fact_seen_q;
	logic oc_seen_q;
	always_ff @(posedge clk)
	begin
		user_seen_q <= resetn & (user_seen_q | user_mismatch);
		fact_seen_q <= resetn & (fact_seen_q | factory_crc_fault);
		oc_seen_q <= resetn & (oc_seen_q | (oc_intervals_expired & filter_normal_mode));
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence st_rd;
		read && address == 8'h30 && !waitrequest;
	endsequence
	sequence cfg6_wr;
		write && address == 8'h24 && byteenable[0] && !waitrequest && ten_bit_mode;
	endsequence
	sequence cfg7_wr;
		write && address == 8'h28 && byteenable[0] && !waitrequest && ten_bit_mode;
	endsequence
	bus_answer_a: assert property ((read || write) |-> ##[0:2] !waitrequest)
		else $error("bus request not answered");
	status_zero_a: assert property (st_rd |-> readdata[31:7] == 0 && !readdata[0])
		else $error("status fixed bits wrong");
	test_flag_a: assert property (st_rd |-> readdata[6] == !$past(test_mode_active, 2))
		else $error("test flag wrong");
	user_sticky_a: assert property (st_rd ##0 $past(user_seen_q) |-> !readdata[4])
		else $error("user flag not held");
	fact_sticky_a: assert property (st_rd ##0 $past(fact_seen_q) |-> !readdata[2])
		else $error("factory flag not held");
	oc_done_a: assert property (st_rd |-> readdata[3] == $past(oc_seen_q))
		else $error("offset cancel flag wrong");
	offset_flag_a: assert property (st_rd |-> readdata[1] == !$past(offset_limit_hit, 2))
		else $error("offset flag wrong");
	mode8_zero_a: assert property ($past(resetn) && !$past(ten_bit_mode) |-> ext_fields_q == 0 && julian_year_q == 0)
		else $error("fields sent in 8-bit mode");
	dir_nibble_a: assert property (cfg6_wr ##1 ten_bit_mode |=> d8_direction_q == {$past(writedata[5:4], 2), 2'b00})
		else $error("direction nibble wrong");
	year_code_a: assert property (cfg7_wr ##1 ten_bit_mode |=> julian_year_q == {3'b000, $past(writedata[3:0], 2)} + 7'h09)
		else $error("year code wrong");
	year_range_a: assert property (julian_year_q == 0 || julian_year_q inside {[9:24]})
		else $error("year code out of range");
	slot_prog_a: assert property ($past(resetn) && $past(timeslot_sel) != 0 |-> slot_mode_q == 2'h2 && slot_half_us_q == $past(timeslot_sel))
		else $error("programmed slot wrong");
	slot_zero_a: assert property ($past(resetn) && $past(timeslot_sel) == 0 |-> slot_mode_q != 2'h2 && slot_half_us_q == 0)
		else $error("zero slot wrong");
endmodule
bind user_otp_status_registers otp_regs_sva chk_i (.*);

/* dv/ecu_init2_rx.sv */
// ECU side receiver that collects the init phase 2 fields
`timescale 1ns/1ps
module ecu_init2_rx
(
	input logic clk,
	input logic [3:0] d8,
	input logic [3:0] rev,
	input logic [6:0] year_code,
	input logic [3:0] month_code,
	input logic [4:0] day_code,
	input logic [7:0] mc,
	input logic [23:0] ext,
	output logic [55:0] frame
);
	always_ff @(posedge clk)
		frame <= {d8, rev, year_code, month_code, day_code, mc, ext};
endmodule

/* dv/user_otp_status_registers_tb.sv */
// Self-checking bench of the user OTP register bank
`timescale 1ns/1ps
module user_otp_status_registers_tb;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] address = 8'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h00000000;
	logic [3:0] byteenable = 4'hF;
	logic ten_bit_mode = 1'b0;
	logic [9:0] timeslot_sel = 10'h000;
	logic [23:0] ext_content = 24'hABCDEF;
	logic test_mode_active = 1'b0;
	logic user_mismatch = 1'b0;
	logic factory_crc_fault = 1'b0;
	logic oc_intervals_expired = 1'b0;
	logic filter_normal_mode = 1'b0;
	logic offset_limit_hit = 1'b0;
	wire [31:0] readdata;
	wire waitrequest;
	wire irq_q;
	wire [1:0] slot_mode_q;
	wire [9:0] slot_half_us_q;
	wire [3:0] d8_direction_q;
	wire [3:0] revision_q;
	wire [6:0] julian_year_q;
	wire [3:0] julian_month_q;
	wire [4:0] julian_day_q;
	wire [7:0] maker_code_q;
	wire [23:0] ext_fields_q;
	wire [55:0] frame;
	logic [31:0] v;
	logic [7:0] ra [4] = '{8'h24, 8'h28, 8'h2C, 8'h34};
	int n_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	int i;
	user_otp_status_registers dut (.*);
	ecu_init2_rx ecu (.clk(clk), .d8(d8_direction_q), .rev(revision_q),
		.year_code(julian_year_q), .month_code(julian_month_q), .day_code(julian_day_q),
		.mc(maker_code_q), .ext(ext_fields_q), .frame(frame));
	initial
	begin
		forever #2.5 clk = ~clk;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		address <= a;
		writedata <= {24'h000000, d};
		write <= 1'b1;
		@(posedge clk);
		while (waitrequest !== 1'b0) @(posedge clk);
		write <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		address <= a;
		read <= 1'b1;
		@(posedge clk);
		while (waitrequest !== 1'b0) @(posedge clk);
		d = readdata;
		read <= 1'b0;
		@(posedge clk);
	endtask
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		comparisons++;
		if (g !== e)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic end_sim;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			n_errors++;
			end_sim();
		end
	end
	initial
	begin
		step(10);
		resetn <= 1'b1;
		step(2);
		foreach (ra[i])
		begin
			rd(ra[i], v);
			chk("cfg reset", 32'h00000000, v);
		end
		rd(8'h30, v);
		chk("status reset", 32'h00000056, v);
		ten_bit_mode <= 1'b1;
		for (i = 0; i < 4; i++)
		begin
			wr(8'h24, {2'b00, i[1:0], 4'h9});
			step(2);
			chk("dir", {i[1:0], 2'b00, 4'h9, 24'h000000}, {d8_direction_q, revision_q, ext_fields_q});
		end
		wr(8'h24, 8'hB5);
		wr(8'h28, 8'hCF);
		wr(8'h2C, 8'hFF);
		wr(8'h34, 8'hA5);
		step(3);
		chk("frame max", {4'hC, 4'h5, 7'h18, 4'hC, 5'h1F, 8'hA5, 24'hABCDEF}, frame);
		rd(8'h2C, v);
		chk("spare", 32'h000000FF, v);
		wr(8'h28, 8'h10);
		wr(8'h2C, 8'h01);
		step(3);
		chk("frame min", {4'hC, 4'h5, 7'h09, 4'h1, 5'h01, 8'hA5, 24'hABCDEF}, frame);
		ten_bit_mode <= 1'b0;
		step(3);
		chk("frame off", 56'h0, frame);
		wr(8'h24, 8'h40);
		step(2);
		chk("async", {2'h1, 10'h000}, {slot_mode_q, slot_half_us_q});
		timeslot_sel <= 10'h3FF;
		step(2);
		chk("prog", {2'h2, 10'h3FF}, {slot_mode_q, slot_half_us_q});
		timeslot_sel <= 10'h000;
		wr(8'h24, 8'h00);
		step(2);
		chk("dflt", {2'h0, 10'h000}, {slot_mode_q, slot_half_us_q});
		wr(8'h44, 8'h01);
		wr(8'h30, 8'hFF);
		test_mode_active <= 1'b1;
		offset_limit_hit <= 1'b1;
		factory_crc_fault <= 1'b1;
		oc_intervals_expired <= 1'b1;
		filter_normal_mode <= 1'b1;
		step(1);
		factory_crc_fault <= 1'b0;
		step(2);
		chk("irq masked", 1'b0, irq_q);
		rd(8'h30, v);
		chk("status fault", 32'h00000018, v);
		user_mismatch <= 1'b1;
		test_mode_active <= 1'b0;
		offset_limit_hit <= 1'b0;
		step(1);
		user_mismatch <= 1'b0;
		step(2);
		chk("irq", 1'b1, irq_q);
		rd(8'h30, v);
		chk("status held", 32'h0000004A, v);
		rd(8'h40, v);
		chk("irq status", 32'h0000001F, v);
		wr(8'h40, 8'h01);
		step(2);
		chk("irq clr", 1'b0, irq_q);
		rd(8'h40, v);
		chk("irq w1c", 32'h0000001E, v);
		rd(8'h3C, v);
		chk("unmapped", 32'h00000000, v);
		resetn <= 1'b0;
		step(2);
		resetn <= 1'b1;
		step(2);
		rd(8'h30, v);
		chk("status after reset", 32'h0000005E, v);
		rd(8'h40, v);
		chk("irq status after reset", 32'h00000008, v);
		chk("irq after reset", 1'b0, irq_q);
		end_sim();
	end
endmodule
